// file: bench/gesc_core_props.sv
/*
  checker of the core's port timing.
  assumes a single clock and asynchronous active low reset.
*/
`default_nettype none
module gesc_core_props
  import gesc_pkg::*;
#(
  parameter int REV_CYC = 20
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              motorOn,
  input wire logic              motorOpenDir,
  input wire logic [3:0]        motorSpeed,
  input wire logic              dispSafe,
  input wire logic              dispEntrap,
  input wire logic              dispStatus,
  input wire logic              logStrobe,
  input wire gesc_pkg::gesc_log_t logKind
);
  // slack of two cycles both ways around the reverse time
  localparam int RLO = REV_CYC - 2;
  localparam int RHI = REV_CYC + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==================================================
  // bus handshake
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  // ==================================================
  // motor drive
  property p_spd; motorOn |-> motorSpeed >= 4'h1 && motorSpeed <= 4'hA; endproperty
  a_spd: assert property (p_spd) else $error("speed out of range");
  property p_idle; !motorOn |-> motorSpeed == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("speed while idle");
  property p_stat; dispStatus |-> !motorOn; endproperty
  a_stat: assert property (p_stat) else $error("run with motor on");
  // ==================================================
  // trip sequence
  property p_rev;
    $rose(dispEntrap) |-> motorOn && motorOpenDir != $past(motorOpenDir);
  endproperty
  a_rev: assert property (p_rev) else $error("no reverse");
  property p_safe; $rose(dispEntrap) |-> ##[RLO:RHI] (dispSafe && !motorOn); endproperty
  a_safe: assert property (p_safe) else $error("no safe state");
  property p_log; $rose(dispEntrap) |-> logStrobe && logKind == GESC_LOG_TRIP; endproperty
  a_log: assert property (p_log) else $error("trip not logged");
endmodule
bind gesc_core gesc_core_props #(.REV_CYC(REV_CYC)) u_gesc_core_props (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pready(pready), .motorOn(motorOn), .motorOpenDir(motorOpenDir),
  .motorSpeed(motorSpeed), .dispSafe(dispSafe), .dispEntrap(dispEntrap),
  .dispStatus(dispStatus), .logStrobe(logStrobe), .logKind(logKind));
`default_nettype wire

// file: bench/gesc_motor_model.sv
/*
  motor driver model: current samples while the motor is driven.
  assumes the core clock; jam is commanded by the bench.
*/
`default_nettype none
module gesc_motor_model (
  input  wire logic        clk,
  input  wire logic        motorOn,
  input  wire logic        jam,
  output logic             curValid,
  output logic      [11:0] curSample
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  initial curValid = 1'b0;
  initial curSample = 12'h000;
  // ==================================================
  // sample every 4 cycles; line wobbles when idle so a stale value never passes
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    curValid <= motorOn && ph == 2'h3;
    curSample <= !motorOn ? ~curSample : jam ? 12'hFFF : 12'h100;
  end
endmodule
`default_nettype wire

// file: bench/tb_gesc_core.sv
/*
  testbench of the core: apb tasks, panel buttons, motor model.
  assumes shortened reverse and log-revert counts.
*/
`default_nettype none
module tb_gesc_core;
  import gesc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, btnOpen = 1'b0, btnReset = 1'b0, btnMenu = 1'b0;
  logic secTick = 1'b0, jam = 1'b0, curValid, motorOn, motorOpenDir;
  logic dispSafe, dispEntrap, dispStatus, logStrobe, irq;
  logic [11:0] curSample;
  logic [3:0] motorSpeed;
  gesc_log_t logKind;
  int fail_count = 0, comparisons = 0;
  gesc_core #(.REV_CYC(20), .DLOG_SEC(5)) u_gesc_core (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .btnOpen(btnOpen),
    .btnReset(btnReset), .btnMenu(btnMenu), .secTick(secTick), .curValid(curValid),
    .curSample(curSample), .belowFreezing(1'b0), .motorOn(motorOn),
    .motorOpenDir(motorOpenDir), .motorSpeed(motorSpeed), .dispSafe(dispSafe),
    .dispEntrap(dispEntrap), .dispStatus(dispStatus), .logStrobe(logStrobe),
    .logKind(logKind), .irq(irq));
  gesc_motor_model u_gesc_motor_model (.clk(clk), .motorOn(motorOn), .jam(jam),
    .curValid(curValid), .curSample(curSample));
  initial forever #5 clk = ~clk;
  // ==================================================
  // shared tasks
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // hold the request until pready is sampled high, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // look at pready mid-cycle, where it is settled; the next rising edge completes
    do @(negedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  // buttons are levels; held long enough to pass the synchroniser
  task automatic press(input logic [2:0] b);
    {btnOpen, btnReset, btnMenu} <= b;
    repeat (6) @(posedge clk);
    {btnOpen, btnReset, btnMenu} <= 3'h0;
    repeat (6) @(posedge clk);
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(12'h000, 32'hFFF, 32'h255);
    rd(12'h004, 32'h100, 32'h0);
    rd(12'h008, 32'h3F, 32'h1);
    rd(12'h020, 32'hFFFFFFFF, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, 12'h000, 32'h71A);
    rd(12'h000, 32'hFFF, 32'h255);
    apb(1'b1, 12'h018, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(motorOn), 32'h0);
    press(3'h1);
    rd(12'h008, 32'h3F, 32'h2);
    press(3'h6);
    rd(12'h008, 32'h3F, 32'h4);
    apb(1'b1, 12'h000, 32'h71A);
    rd(12'h000, 32'hFFF, 32'h71A);
    press(3'h1);
    rd(12'h008, 32'h3F, 32'h1);
    apb(1'b1, 12'h004, 32'h10F);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h018, 32'h3);
    chk({motorOn, motorOpenDir, motorSpeed}, 32'h3A);
    rd(12'h01C, 32'h7, 32'h1);
    press(3'h1);
    chk({motorOn, dispStatus}, 32'h2);
    apb(1'b1, 12'h018, 32'h4);
    apb(1'b1, 12'h018, 32'h1);
    chk({motorOn, motorOpenDir, motorSpeed}, 32'h21);
    jam <= 1'b1;
    for (int i = 0; i < 100 && dispEntrap !== 1'b1; i++) @(posedge clk);
    chk({dispEntrap, motorOpenDir}, 32'h3);
    for (int i = 0; i < 100 && dispSafe !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    chk({dispSafe, motorOn, irq}, 32'h5);
    rd(12'h01C, 32'h7, 32'h3);
    jam <= 1'b0;
    apb(1'b1, 12'h00C, 32'h1);
    chk(32'(irq), 32'h0);
    press(3'h1);
    repeat (6) begin
      secTick <= 1'b1;
      @(posedge clk);
      secTick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    rd(12'h004, 32'h10F, 32'hF);
    apb(1'b1, 12'h018, 32'h3);
    apb(1'b1, 12'h018, 32'h4);
    apb(1'b0, 12'h01C, 32'h0);
    chk(32'(rdat[2:0] == 3'h1), 32'h0);
    report_and_stop();
  end
  // ==================================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: core/gesc_core.sv
/*
  gate entrapment and speed control: motor run, speed, current trip with
  adaptive threshold, menu entry conditions, detailed log enable, APB regs.
  assumes a buffered panel, a current sampler with a one-cycle valid,
  and a one-pulse-per-second timebase, all on clk.
*/
// The APB slave port and the register addresses were decided locally.
`include "gesc_regs.svh"
`default_nettype none
module gesc_core
  import gesc_pkg::*;
#(
  parameter int          AVG_LOG2    = 3,
  parameter int          CUR_W       = 12,
  parameter logic [11:0] HEAD_STEP   = 12'h020,
  parameter logic [11:0] FIXED_LIMIT = 12'hE00,
  parameter logic [11:0] BOOST       = 12'h100,
  parameter int          REV_CYC     = `GESC_REV_CYC,
  parameter int          DLOG_SEC    = `GESC_DLOG_SEC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              btnOpen,
  input  wire logic              btnReset,
  input  wire logic              btnMenu,
  input  wire logic              secTick,
  input  wire logic              curValid,
  input  wire logic [11:0]       curSample,
  input  wire logic              belowFreezing,
  output logic                   motorOn,
  output logic                   motorOpenDir,
  output logic      [3:0]        motorSpeed,
  output logic                   dispSafe,
  output logic                   dispEntrap,
  output logic                   dispStatus,
  output logic                   logStrobe,
  output gesc_pkg::gesc_log_t    logKind,
  output logic                   irq
);
  localparam int AW = CUR_W + AVG_LOG2;
  localparam int DW = $clog2(DLOG_SEC + 1);
  localparam int RW = $clog2(REV_CYC + 1);

  typedef struct packed {
    gesc_state_t st;
    logic [2:0]  sync;     // open, reset, menu synchronisers stage 1
    logic [2:0]  btn;      // stage 2
    logic [2:0]  btnQ;     // previous stage 2 for edge detect
    logic [3:0]  spdOpen;
    logic [3:0]  spdClose;
    logic [3:0]  sens;
    logic        dlog;
    logic [DW-1:0] dlogCnt;
    logic [3:0]  setupDone; // usage, handing, weight, length
    logic        boost;
    logic        dir;
    logic [AW-1:0] accum;
    logic [RW-1:0] revCnt;
    logic [2:0]  irqSt;
    logic [2:0]  irqMask;
    logic        motorOn;
    logic [3:0]  motorSpeed;
    logic        logStb;
    gesc_log_t   logKind;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } gesc_core_t;

  gesc_core_t s_r, s_nxt;

  // clamp a written level into the legal range
  function automatic logic [3:0] gescClamp(input logic [3:0] v, input logic [3:0] lo,
                                           input logic [3:0] hi);
    gescClamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic [CUR_W-1:0] avg;
  logic [13:0]      head;
  logic [13:0]      thresh;
  logic             apbWr;
  logic             apbRd;
  logic             menuEdge;
  logic             comboEdge;
  logic             trip;
  logic [2:0]       evt;
  logic [3:0]       lvl;

  // threshold: fixed for high settings, average plus headroom otherwise
  always_comb begin
    avg  = s_r.accum[AW-1:AVG_LOG2];
    head = 14'(HEAD_STEP) * 14'(s_r.sens + 4'h1);
    if (belowFreezing) begin
      head = head + (head >> 1);
    end
    if (s_r.sens > 4'h6) begin
      thresh = 14'(FIXED_LIMIT);
    end else begin
      thresh = 14'(avg) + head;
    end
    if (s_r.boost) begin
      thresh = thresh + 14'(BOOST);
    end
  end

  // the answer is prepared on the first access edge, a write lands only on the
  // edge where the master samples pready high, so a held request acts once
  assign apbWr     = psel & penable & pwrite & s_r.pready;
  assign apbRd     = psel & penable & ~s_r.pready;
  assign menuEdge  = s_r.btn[0] & ~s_r.btnQ[0];
  assign comboEdge = s_r.btn[2] & s_r.btn[1] & ~(s_r.btnQ[2] & s_r.btnQ[1]);
  assign trip      = (s_r.st == GESC_MOVE) & curValid & (14'(curSample) > thresh);

  // next-state logic of the whole block
  always_comb begin
    s_nxt         = s_r;
    evt           = 3'h0;
    lvl           = 4'h0;
    s_nxt.sync    = {btnOpen, btnReset, btnMenu};
    s_nxt.btn     = s_r.sync;
    s_nxt.btnQ    = s_r.btn;
    s_nxt.logStb  = 1'b0;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    // running average only while driven, so idle zero current is ignored
    if (s_r.motorOn && curValid) begin
      s_nxt.accum = s_r.accum - AW'(avg) + AW'(curSample);
    end
    // detailed log expiry, counted in seconds
    if (s_r.dlog) begin
      if (secTick) begin
        s_nxt.dlogCnt = s_r.dlogCnt + DW'(1);
      end
      if (s_r.dlogCnt >= DW'(DLOG_SEC)) begin
        s_nxt.dlog    = `GESC_DLOG_RST;
        s_nxt.dlogCnt = '0;
        evt[`GESC_IRQ_REVERT] = 1'b1;
      end
    end else begin
      s_nxt.dlogCnt = '0;
    end
    unique case (s_r.st)
      GESC_RUN: begin
        if (menuEdge) begin
          s_nxt.st = GESC_UMENU;
        end
      end
      GESC_UMENU: begin
        if (comboEdge) begin
          s_nxt.st = GESC_IMENU;
        end else if (menuEdge) begin
          s_nxt.st = GESC_RUN;
        end
      end
      GESC_IMENU: begin
        if (menuEdge) begin
          s_nxt.st = GESC_RUN;
        end
      end
      GESC_MOVE: begin
        if (trip) begin
          s_nxt.st      = GESC_REVERSE;
          s_nxt.dir     = ~s_r.dir;
          s_nxt.revCnt  = RW'(REV_CYC - 1);
          s_nxt.boost   = 1'b1;
          s_nxt.logStb  = 1'b1;
          s_nxt.logKind = GESC_LOG_TRIP;
          evt[`GESC_IRQ_TRIP] = 1'b1;
        end
      end
      GESC_REVERSE: begin
        if (s_r.revCnt == '0) begin
          s_nxt.st = GESC_SAFE;
        end else begin
          s_nxt.revCnt = s_r.revCnt - RW'(1);
        end
      end
      GESC_SAFE: begin
        if (menuEdge) begin
          s_nxt.st = GESC_RUN;
        end
      end
    endcase
    // register writes, only on the access phase
    if (apbWr) begin
      unique case (paddr)
        `GESC_CTRL_OFS: begin
          if (s_r.st == GESC_IMENU) begin
            s_nxt.spdOpen  = gescClamp(pwdata[3:0], 4'h1, 4'hA);
            s_nxt.spdClose = gescClamp(pwdata[7:4], 4'h1, 4'hA);
            s_nxt.sens     = gescClamp(pwdata[11:8], 4'h0, 4'h9);
            s_nxt.logStb   = 1'b1;
            s_nxt.logKind  = GESC_LOG_MENU;
          end
        end
        `GESC_CFG_OFS: begin
          s_nxt.setupDone = pwdata[3:0];
          if (pwdata[8] && !s_r.dlog) begin
            s_nxt.dlogCnt = '0;
          end
          s_nxt.dlog = pwdata[8];
        end
        `GESC_IRQ_OFS: begin
          s_nxt.irqSt = s_r.irqSt & ~pwdata[2:0];
        end
        `GESC_MASK_OFS: begin
          s_nxt.irqMask = pwdata[2:0];
        end
        `GESC_CMD_OFS: begin
          // start a travel only when idle and fully set up
          if (s_r.st == GESC_RUN && (&s_r.setupDone) && pwdata[0]) begin
            s_nxt.st    = GESC_MOVE;
            s_nxt.dir   = pwdata[1];
            if (s_r.dlog) begin
              s_nxt.logStb  = 1'b1;
              s_nxt.logKind = pwdata[1] ? GESC_LOG_OPEN : GESC_LOG_CLOSE;
            end
          end else if (s_r.st == GESC_MOVE && pwdata[2]) begin
            s_nxt.st    = GESC_RUN;
            s_nxt.boost = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    evt[`GESC_IRQ_LOG] = s_nxt.logStb;
    s_nxt.irqSt = s_nxt.irqSt | evt;                                    // set wins over clear
    s_nxt.irq   = |(s_nxt.irqSt & s_nxt.irqMask);
    // motor drive follows the next state
    s_nxt.motorOn = (s_nxt.st == GESC_MOVE) || (s_nxt.st == GESC_REVERSE);
    lvl = s_nxt.dir ? s_nxt.spdOpen : s_nxt.spdClose;
    s_nxt.motorSpeed = s_nxt.motorOn ? lvl : 4'h0;
    // read mux
    if (apbRd) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0;
      unique case (paddr)
        `GESC_CTRL_OFS:  s_nxt.prdata = {20'h0, s_r.sens, s_r.spdClose, s_r.spdOpen};
        `GESC_CFG_OFS:   s_nxt.prdata = {23'h0, s_r.dlog, 4'h0, s_r.setupDone};
        `GESC_STAT_OFS:  s_nxt.prdata = {25'h0, s_r.boost, s_r.dir, 3'h0, s_r.st[5:4]} |
                                        {26'h0, s_r.st};
        `GESC_IRQ_OFS:   s_nxt.prdata = {29'h0, s_r.irqSt};
        `GESC_MASK_OFS:  s_nxt.prdata = {29'h0, s_r.irqMask};
        `GESC_AVG_OFS:   s_nxt.prdata = {20'h0, avg};
        `GESC_CMD_OFS:   s_nxt.prdata = 32'h0;
        `GESC_LOGEV_OFS: s_nxt.prdata = {29'h0, s_r.logKind};
        default:         s_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // one register for the whole state; asynchronous reset to constants
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r          <= '0;
      s_r.st       <= GESC_RUN;
      s_r.spdOpen  <= `GESC_SPEED_RST;
      s_r.spdClose <= `GESC_SPEED_RST;
      s_r.sens     <= `GESC_SENS_RST;
      s_r.dlog     <= `GESC_DLOG_RST;
      s_r.logKind  <= GESC_LOG_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign motorOn      = s_r.motorOn;
  assign motorOpenDir = s_r.dir;
  assign motorSpeed   = s_r.motorSpeed;
  assign dispSafe     = s_r.st[5];
  assign dispEntrap   = s_r.st[4];
  assign dispStatus   = s_r.st[0];
  assign logStrobe    = s_r.logStb;
  assign logKind      = s_r.logKind;
  assign irq          = s_r.irq;
endmodule
`default_nettype wire

// file: core/gesc_pkg.sv
/*
  types of the gate entrapment and speed control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package gesc_pkg;
  // ========================================================================
  // top level operating state, one-hot
  typedef enum logic [5:0] {
    GESC_RUN     = 6'h01,
    GESC_UMENU   = 6'h02,
    GESC_IMENU   = 6'h04,
    GESC_MOVE    = 6'h08,
    GESC_REVERSE = 6'h10,
    GESC_SAFE    = 6'h20
  } gesc_state_t;
  // log event kinds
  typedef enum logic [2:0] {
    GESC_LOG_NONE  = 3'h0,
    GESC_LOG_OPEN  = 3'h1,
    GESC_LOG_CLOSE = 3'h2,
    GESC_LOG_TRIP  = 3'h3,
    GESC_LOG_MENU  = 3'h4
  } gesc_log_t;
endpackage
`default_nettype wire

// file: core/gesc_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  gate entrapment and speed control block.
  assumes a 100 MHz clock and a 32-bit APB slave port.
*/
`ifndef GESC_REGS_SVH
`define GESC_REGS_SVH
// ==========================================================================
// register byte offsets
`define GESC_CTRL_OFS      12'h000
`define GESC_CFG_OFS       12'h004
`define GESC_STAT_OFS      12'h008
`define GESC_IRQ_OFS       12'h00C
`define GESC_MASK_OFS      12'h010
`define GESC_AVG_OFS       12'h014
`define GESC_CMD_OFS       12'h018
`define GESC_LOGEV_OFS     12'h01C
// ==========================================================================
// reset values
`define GESC_SPEED_RST     4'h5
`define GESC_SENS_RST      4'h2
`define GESC_DLOG_RST      1'b0
// ==========================================================================
// timing: times in their own units, reverse count derived at 100 MHz, log-revert count in seconds
`define GESC_CLK_HZ        100000000
`define GESC_REV_MS        2000
`define GESC_REV_CYC       ((`GESC_CLK_HZ / 1000) * `GESC_REV_MS)
`define GESC_DLOG_HOURS    24
`define GESC_DLOG_SEC      (`GESC_DLOG_HOURS * 3600)
// ==========================================================================
// irq bit positions
`define GESC_IRQ_TRIP      0
`define GESC_IRQ_LOG       1
`define GESC_IRQ_REVERT    2
`endif
